// >>> logic/general_timer_defines.vh
`ifndef GENERAL_TIMER_DEFINES_VH
`define GENERAL_TIMER_DEFINES_VH

// ==========================================================
// Configuration and mode codes
`define CFG_32_PERIODIC   3'h0
`define CFG_32_CLOCK      3'h1
`define CFG_16_SPLIT      3'h4
`define MODE_ONE_SHOT     2'h1
`define MODE_PERIODIC     2'h2

// ==========================================================
// Reset values
`define COUNTER_RESET     16'hFFFF
`define PRESCALE_RESET    8'h00
`define CLOCK_FIRST_LOAD  32'h0000_0001

// ==========================================================
// Status bit positions
`define STAT_A_TIMEOUT    0
`define STAT_B_TIMEOUT    1
`define STAT_CLOCK_MATCH  2
`define STAT_WIDTH        3

// ==========================================================
// Clock-mode divider: input edges per 1 Hz tick
`define CLOCK_IN_HZ       32768
`define CLOCK_OUT_HZ      1
`define CLOCK_DIV_COUNT   (`CLOCK_IN_HZ / `CLOCK_OUT_HZ)
`define CLOCK_DIV_LAST    15'h7FFF

`endif

// >>> logic/clock_tick_divider.v
`timescale 1ns/1ps
`default_nettype none
`include "general_timer_defines.vh"
module clock_tick_divider (
   input  wire i_clk,
   input  wire i_rst_n,
   input  wire i_active,
   input  wire i_ccp,
   output reg  o_tick
);
   reg        sync1_reg;
   reg        sync2_reg;
   reg        prev_reg;
   reg [14:0] div_reg;

   localparam [14:0] DIV_LAST = `CLOCK_DIV_LAST;

   wire rise = sync2_reg & ~prev_reg;

   // ==========================================================
   // Pin synchroniser, edge count and 1 Hz tick
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg  <= 1'b0;
         div_reg   <= 15'h0000;
         o_tick    <= 1'b0;
      end else begin
         sync1_reg <= i_ccp;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
         o_tick    <= 1'b0;
         if (!i_active) begin
            div_reg <= 15'h0000;
         end else if (rise) begin
            if (div_reg == DIV_LAST) begin
               div_reg <= 15'h0000;
               o_tick  <= 1'b1;
            end else begin
               div_reg <= div_reg + 15'h0001;
            end
         end
      end
   end
endmodule // clock_tick_divider
`default_nettype wire

// >>> logic/timer_status_flags.v
`timescale 1ns/1ps
`default_nettype none
`include "general_timer_defines.vh"
module timer_status_flags (
   input  wire                    i_clk,
   input  wire                    i_rst_n,
   input  wire [`STAT_WIDTH-1:0]  i_set,
   input  wire                    i_clear_wr,
   input  wire [`STAT_WIDTH-1:0]  i_clear,
   input  wire [`STAT_WIDTH-1:0]  i_mask,
   output reg  [`STAT_WIDTH-1:0]  o_raw,
   output reg  [`STAT_WIDTH-1:0]  o_masked,
   output reg                     o_irq
);
   reg [`STAT_WIDTH-1:0] raw_next;

   // ==========================================================
   // Sticky flags, set wins over clear
   always @* begin
      raw_next = o_raw;
      if (i_clear_wr) begin
         raw_next = raw_next & ~i_clear;
      end
      raw_next = raw_next | i_set;
   end

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_raw    <= {`STAT_WIDTH{1'b0}};
         o_masked <= {`STAT_WIDTH{1'b0}};
         o_irq    <= 1'b0;
      end else begin
         o_raw    <= raw_next;
         o_masked <= raw_next & i_mask;
         o_irq    <= |(raw_next & i_mask);
      end
   end
endmodule // timer_status_flags
`default_nettype wire

// >>> logic/general_timer_module.v
`timescale 1ns/1ps
`default_nettype none
`include "general_timer_defines.vh"
module general_timer_module (
   input  wire                    i_clk,
   input  wire                    i_rst_n,
   input  wire [2:0]              i_timer_config,
   input  wire [1:0]              i_counter_a_mode_field,
   input  wire [1:0]              i_counter_b_mode_field,
   input  wire                    i_a_enable_set,
   input  wire                    i_a_enable_clear,
   input  wire                    i_b_enable_set,
   input  wire                    i_b_enable_clear,
   input  wire                    i_a_load_wr,
   input  wire [31:0]             i_a_load_data,
   input  wire                    i_b_load_wr,
   input  wire [15:0]             i_b_load_data,
   input  wire                    i_a_prescale_wr,
   input  wire [7:0]              i_a_prescale_data,
   input  wire                    i_b_prescale_wr,
   input  wire [7:0]              i_b_prescale_data,
   input  wire                    i_counter_a_freeze_bit,
   input  wire                    i_counter_b_freeze_bit,
   input  wire                    i_clock_freeze_override_bit,
   input  wire                    i_counter_a_trigger_out_enable,
   input  wire                    i_counter_b_trigger_out_enable,
   input  wire [31:0]             i_counter_a_match,
   input  wire [`STAT_WIDTH-1:0]  i_irq_mask,
   input  wire                    i_irq_clear_wr,
   input  wire [`STAT_WIDTH-1:0]  i_irq_clear,
   input  wire                    i_capture_compare_pin_0,
   output reg  [31:0]             o_counter_a_value,
   output reg  [15:0]             o_counter_b_value,
   output reg                     o_a_enable,
   output reg                     o_b_enable,
   output reg                     o_a_trigger,
   output reg                     o_b_trigger,
   output wire [`STAT_WIDTH-1:0]  o_raw_status,
   output wire [`STAT_WIDTH-1:0]  o_masked_status,
   output wire                    o_irq
);
   // ==========================================================
   // State
   reg [15:0] cnt_a_reg;
   reg [15:0] cnt_b_reg;
   reg [15:0] load_a_reg;
   reg [15:0] load_b_reg;
   reg [7:0]  pre_a_reg;
   reg [7:0]  pre_b_reg;
   reg [7:0]  precnt_a_reg;
   reg [7:0]  precnt_b_reg;
   reg        clock_seen_reg;

   reg [15:0] cnt_a_next;
   reg [15:0] cnt_b_next;
   reg [15:0] load_a_next;
   reg [15:0] load_b_next;
   reg [7:0]  pre_a_next;
   reg [7:0]  pre_b_next;
   reg [7:0]  precnt_a_next;
   reg [7:0]  precnt_b_next;
   reg        en_a_next;
   reg        en_b_next;
   reg        clock_seen_next;
   reg        timeout_a;
   reg        timeout_b;
   reg        clock_match;

   wire        clock_tick;
   wire [31:0] cnt32 = {cnt_b_reg, cnt_a_reg};
   wire [25:0] step_a;
   wire [25:0] step_b;
   wire        mode_32 = (i_timer_config == `CFG_32_PERIODIC);
   wire        mode_clock = (i_timer_config == `CFG_32_CLOCK);
   wire        mode_16 = (i_timer_config == `CFG_16_SPLIT);
   wire        clock_frozen = (i_counter_a_freeze_bit |
                               i_counter_b_freeze_bit) &
                              ~i_clock_freeze_override_bit;

   // ==========================================================
   // One 16-bit prescaled down-counter step
   // Result: {enable, timeout, prescale count, count}
   function [25:0] step16;
      input        en;
      input        freeze;
      input [1:0]  mode;
      input [7:0]  precnt;
      input [7:0]  pre;
      input [15:0] cnt;
      input [15:0] load;
      begin
         step16 = {en, 1'b0, precnt, cnt};
         if (en && !freeze) begin
            if (precnt != 8'h00) begin
               step16 = {en, 1'b0, precnt - 8'h01, cnt};
            end else if (cnt == 16'h0000) begin
               step16 = {(mode != `MODE_ONE_SHOT), 1'b1,
                         pre, load};
            end else begin
               step16 = {en, 1'b0, pre, cnt - 16'h0001};
            end
         end
      end
   endfunction

   // ==========================================================
   // Per-counter steps, slot 0 is counter A and slot 1 counter B
   wire [1:0]  ch_en     = {o_b_enable, o_a_enable};
   wire [1:0]  ch_freeze = {i_counter_b_freeze_bit,
                            i_counter_a_freeze_bit};
   wire [3:0]  ch_mode   = {i_counter_b_mode_field,
                            i_counter_a_mode_field};
   wire [15:0] ch_precnt = {precnt_b_reg,
                            precnt_a_reg};
   wire [15:0] ch_pre    = {pre_b_reg,
                            pre_a_reg};
   wire [31:0] ch_load   = {load_b_reg,
                            load_a_reg};
   wire [51:0] ch_step;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_step
         assign ch_step[ch*26 +: 26] = step16(ch_en[ch],
                                              ch_freeze[ch],
                                              ch_mode[ch*2 +: 2],
                                              ch_precnt[ch*8 +: 8],
                                              ch_pre[ch*8 +: 8],
                                              cnt32[ch*16 +: 16],
                                              ch_load[ch*16 +: 16]);
      end
   endgenerate

   assign step_a = ch_step[25:0];
   assign step_b = ch_step[51:26];

   // ==========================================================
   // Next-state logic
   always @* begin
      cnt_a_next      = cnt_a_reg;
      cnt_b_next      = cnt_b_reg;
      load_a_next     = load_a_reg;
      load_b_next     = load_b_reg;
      pre_a_next      = pre_a_reg;
      pre_b_next      = pre_b_reg;
      precnt_a_next   = precnt_a_reg;
      precnt_b_next   = precnt_b_reg;
      en_a_next       = o_a_enable;
      en_b_next       = o_b_enable;
      clock_seen_next = clock_seen_reg;
      timeout_a       = 1'b0;
      timeout_b       = 1'b0;
      clock_match     = 1'b0;
      case (i_timer_config)
         `CFG_32_PERIODIC: begin
            if (o_a_enable && !i_counter_a_freeze_bit) begin
               if (cnt32 == 32'h0000_0000) begin
                  {cnt_b_next, cnt_a_next} = {load_b_reg,
                                              load_a_reg};
                  timeout_a = 1'b1;
                  if (i_counter_a_mode_field == `MODE_ONE_SHOT) begin
                     en_a_next = 1'b0;
                  end
               end else begin
                  {cnt_b_next, cnt_a_next} = cnt32 -
                                             32'h0000_0001;
               end
            end
         end
         `CFG_32_CLOCK: begin
            if (!clock_seen_reg) begin
               {cnt_b_next, cnt_a_next} = `CLOCK_FIRST_LOAD;
               clock_seen_next = 1'b1;
            end else if (o_a_enable && clock_tick && !clock_frozen) begin
               if (cnt32 == i_counter_a_match) begin
                  {cnt_b_next, cnt_a_next} = 32'h0000_0000;
                  clock_match = 1'b1;
               end else begin
                  {cnt_b_next, cnt_a_next} = cnt32 +
                                             32'h0000_0001;
               end
            end
         end
         `CFG_16_SPLIT: begin
            {en_a_next, timeout_a, precnt_a_next, cnt_a_next} = step_a;
            {en_b_next, timeout_b, precnt_b_next, cnt_b_next} = step_b;
         end
         default: begin
            en_a_next = o_a_enable;
         end
      endcase
      // Software load writes take effect next cycle
      if (i_a_load_wr) begin
         load_a_next = i_a_load_data[15:0];
         cnt_a_next  = i_a_load_data[15:0];
         if (mode_32 || mode_clock) begin
            load_b_next = i_a_load_data[31:16];
            cnt_b_next  = i_a_load_data[31:16];
         end
      end
      if (i_b_load_wr && mode_16) begin
         load_b_next = i_b_load_data;
         cnt_b_next  = i_b_load_data;
      end
      if (i_a_prescale_wr) begin
         pre_a_next    = i_a_prescale_data;
         precnt_a_next = i_a_prescale_data;
      end
      if (i_b_prescale_wr) begin
         pre_b_next    = i_b_prescale_data;
         precnt_b_next = i_b_prescale_data;
      end
      if (i_a_enable_clear) begin
         en_a_next = 1'b0;
      end
      if (i_a_enable_set) begin
         en_a_next = 1'b1;
      end
      if (i_b_enable_clear) begin
         en_b_next = 1'b0;
      end
      if (i_b_enable_set) begin
         en_b_next = 1'b1;
      end
   end

   // ==========================================================
   // Registers
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_a_reg         <= `COUNTER_RESET;
         cnt_b_reg         <= `COUNTER_RESET;
         load_a_reg        <= `COUNTER_RESET;
         load_b_reg        <= `COUNTER_RESET;
         pre_a_reg         <= `PRESCALE_RESET;
         pre_b_reg         <= `PRESCALE_RESET;
         precnt_a_reg      <= `PRESCALE_RESET;
         precnt_b_reg      <= `PRESCALE_RESET;
         clock_seen_reg    <= 1'b0;
         o_a_enable        <= 1'b0;
         o_b_enable        <= 1'b0;
      end else begin
         cnt_a_reg      <= cnt_a_next;
         cnt_b_reg      <= cnt_b_next;
         load_a_reg     <= load_a_next;
         load_b_reg     <= load_b_next;
         pre_a_reg      <= pre_a_next;
         pre_b_reg      <= pre_b_next;
         precnt_a_reg   <= precnt_a_next;
         precnt_b_reg   <= precnt_b_next;
         clock_seen_reg <= clock_seen_next;
         o_a_enable     <= en_a_next;
         o_b_enable     <= en_b_next;
      end
   end

   // ==========================================================
   // Trigger pulses, one cycle after a time-out
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_a_trigger <= 1'b0;
         o_b_trigger <= 1'b0;
      end else begin
         o_a_trigger <= timeout_a &
                        i_counter_a_trigger_out_enable;
         o_b_trigger <= timeout_b &
                        i_counter_b_trigger_out_enable;
      end
   end

   // ==========================================================
   // Value outputs, showing the count of the current cycle
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_counter_a_value <= {`COUNTER_RESET, `COUNTER_RESET};
         o_counter_b_value <= `COUNTER_RESET;
      end else begin
         if (mode_16) begin
            o_counter_a_value <= {16'h0000, cnt_a_next};
         end else begin
            o_counter_a_value <= {cnt_b_next, cnt_a_next};
         end
         o_counter_b_value <= cnt_b_next;
      end
   end

   // ==========================================================
   // Clock-mode divider and status flags
   clock_tick_divider u_divider (
      .i_clk    (i_clk),
      .i_rst_n  (i_rst_n),
      .i_active (mode_clock & o_a_enable),
      .i_ccp    (i_capture_compare_pin_0),
      .o_tick   (clock_tick)
   );

   timer_status_flags u_status (
      .i_clk      (i_clk),
      .i_rst_n    (i_rst_n),
      .i_set      ({clock_match, timeout_b, timeout_a}),
      .i_clear_wr (i_irq_clear_wr),
      .i_clear    (i_irq_clear),
      .i_mask     (i_irq_mask),
      .o_raw      (o_raw_status),
      .o_masked   (o_masked_status),
      .o_irq      (o_irq)
   );
endmodule // general_timer_module
`default_nettype wire

// >>> tb/general_timer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Port checker for the timer
module general_timer_monitor (
   input wire        i_clk,
   input wire        i_rst_n,
   input wire [2:0]  i_timer_config,
   input wire [1:0]  i_counter_a_mode_field,
   input wire        i_a_enable_set,
   input wire        i_a_enable_clear,
   input wire        i_a_load_wr,
   input wire [31:0] i_a_load_data,
   input wire        i_counter_a_freeze_bit,
   input wire        i_counter_a_trigger_out_enable,
   input wire [2:0]  i_irq_mask,
   input wire        i_irq_clear_wr,
   input wire [31:0] o_counter_a_value,
   input wire        o_a_enable,
   input wire        o_a_trigger,
   input wire [2:0]  o_raw_status,
   input wire [2:0]  o_masked_status,
   input wire        o_irq
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence quiet_a;
      !i_a_load_wr && !i_a_enable_set && !i_a_enable_clear;
   endsequence
   sequence a_zero;
      quiet_a ##0 (i_timer_config == 3'h0 && o_a_enable &&
         !i_counter_a_freeze_bit && o_counter_a_value == 32'h0000_0000);
   endsequence
   irq_any_a: assert property (o_irq == |o_masked_status)
      else $error("irq differs from masked flags");
   mask_and_a: assert property (
      o_masked_status == (o_raw_status & $past(i_irq_mask)))
      else $error("masked flags not raw and mask");
   trig_gate_a: assert property (
      o_a_trigger |-> $past(i_counter_a_trigger_out_enable))
      else $error("trigger without trigger enable");
   raw_hold_a: assert property (
      o_raw_status[0] && !i_irq_clear_wr |=> o_raw_status[0])
      else $error("raw flag dropped without clear");
   load_take_a: assert property (
      i_a_load_wr && i_timer_config == 3'h0
      |=> o_counter_a_value == $past(i_a_load_data))
      else $error("load write not taken");
   count_down_a: assert property (
      quiet_a ##0 (i_timer_config == 3'h0 && o_a_enable &&
      !i_counter_a_freeze_bit && o_counter_a_value != 0)
      |=> o_counter_a_value == $past(o_counter_a_value) - 1)
      else $error("count not down by one");
   freeze_hold_a: assert property (
      quiet_a ##0 (i_timer_config != 3'h1 &&
      i_timer_config == $past(i_timer_config) && i_counter_a_freeze_bit)
      |=> $stable(o_counter_a_value))
      else $error("frozen counter moved");
   oneshot_end_a: assert property (
      a_zero ##0 i_counter_a_mode_field == 2'h1
      |=> !o_a_enable && o_raw_status[0])
      else $error("one-shot did not stop");
   trig_fire_a: assert property (
      a_zero ##0 i_counter_a_trigger_out_enable |=> o_a_trigger)
      else $error("trigger missing at time-out");
endmodule // general_timer_monitor
bind general_timer_module general_timer_monitor general_timer_monitor_inst (
   .i_clk, .i_rst_n, .i_timer_config, .i_counter_a_mode_field,
   .i_a_enable_set, .i_a_enable_clear, .i_a_load_wr, .i_a_load_data,
   .i_counter_a_freeze_bit, .i_counter_a_trigger_out_enable, .i_irq_mask,
   .i_irq_clear_wr, .o_counter_a_value, .o_a_enable, .o_a_trigger,
   .o_raw_status, .o_masked_status, .o_irq);
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        i_clk = '0, i_rst_n = '0, i_a_enable_set = '0;
   logic        i_a_enable_clear = '0, i_b_enable_set = '0;
   logic        i_b_enable_clear = '0, i_a_load_wr = '0, i_b_load_wr = '0;
   logic        i_a_prescale_wr = '0, i_b_prescale_wr = '0;
   logic        i_counter_a_freeze_bit = '0, i_counter_b_freeze_bit = '0;
   logic        i_clock_freeze_override_bit = '0, i_irq_clear_wr = '0;
   logic        i_counter_a_trigger_out_enable = '0;
   logic        i_counter_b_trigger_out_enable = '0;
   logic        i_capture_compare_pin_0 = '0;
   logic [2:0]  i_timer_config = '0, i_irq_mask = '0, i_irq_clear = '0;
   logic [1:0]  i_counter_a_mode_field = '0, i_counter_b_mode_field = '0;
   logic [31:0] i_a_load_data = '0, i_counter_a_match = 32'h0000_0005;
   logic [15:0] i_b_load_data = '0;
   logic [7:0]  i_a_prescale_data = '0, i_b_prescale_data = '0;
   logic [31:0] o_counter_a_value;
   logic [15:0] o_counter_b_value;
   logic        o_a_enable, o_b_enable, o_a_trigger, o_b_trigger, o_irq;
   logic [2:0]  o_raw_status, o_masked_status;
   logic [15:0] rows [0:2];
   int          fail_count = 0, comparisons = 0, n;

   always #10 i_clk = ~i_clk;

   general_timer_module general_timer_module_inst (
      .i_clk, .i_rst_n, .i_timer_config, .i_counter_a_mode_field,
      .i_counter_b_mode_field, .i_a_enable_set, .i_a_enable_clear,
      .i_b_enable_set, .i_b_enable_clear, .i_a_load_wr, .i_a_load_data,
      .i_b_load_wr, .i_b_load_data, .i_a_prescale_wr, .i_a_prescale_data,
      .i_b_prescale_wr, .i_b_prescale_data, .i_counter_a_freeze_bit,
      .i_counter_b_freeze_bit, .i_clock_freeze_override_bit,
      .i_counter_a_trigger_out_enable, .i_counter_b_trigger_out_enable,
      .i_counter_a_match, .i_irq_mask, .i_irq_clear_wr, .i_irq_clear,
      .i_capture_compare_pin_0, .o_counter_a_value, .o_counter_b_value,
      .o_a_enable, .o_b_enable, .o_a_trigger, .o_b_trigger,
      .o_raw_status, .o_masked_status, .o_irq);

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      $display("Mismatches %0d of %0d checks", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Edges until a raw flag shows, bounded
   task automatic wait_raw(input int b);
      n = 0;
      do begin
         @(posedge i_clk);
         #1;
         n++;
         if (n > 400) begin
            fail_count++;
            give_verdict();
         end
      end while (o_raw_status[b] !== 1'h1);
   endtask

   initial begin
      // Rows: modes A/B, trigger enable, mask, load
      rows = '{16'h6C05, 16'h9002, 16'h4800};
      repeat (12) @(posedge i_clk);
      chk(o_counter_a_value, 32'hFFFF_FFFF);
      chk(o_counter_b_value, 16'hFFFF);
      chk({o_a_enable, o_b_enable, o_raw_status, o_irq}, '0);
      i_rst_n <= 1'h1;
      // ========================================
      // 32-bit time-out table
      foreach (rows[i]) begin
         @(posedge i_clk);
         {i_counter_a_mode_field, i_counter_b_mode_field} <= rows[i][15:12];
         i_counter_a_trigger_out_enable <= rows[i][11];
         i_irq_mask <= {2'h0, rows[i][10]};
         i_a_load_wr <= 1'h1;
         i_a_load_data <= {24'h00_0000, rows[i][7:0]};
         @(posedge i_clk);
         i_a_load_wr <= 1'h0;
         i_a_enable_set <= 1'h1;
         @(posedge i_clk);
         i_a_enable_set <= 1'h0;
         wait_raw(0);
         chk(n, rows[i][7:0] + 1);
         chk(o_counter_a_value, rows[i][7:0]);
         chk(o_a_enable, rows[i][15:14] == 2'h2);
         chk(o_a_trigger, rows[i][11]);
         chk(o_irq, rows[i][10]);
         @(posedge i_clk);
         i_a_enable_clear <= 1'h1;
         i_irq_clear_wr <= 1'h1;
         i_irq_clear <= 3'h6;
         @(posedge i_clk);
         i_a_enable_clear <= 1'h0;
         i_irq_clear <= 3'h1;
         #1 chk(o_raw_status[0], 1'h1);
         @(posedge i_clk);
         i_irq_clear_wr <= 1'h0;
         #1 chk(o_raw_status, '0);
      end
      // ========================================
      // Split load, freeze, live reload
      @(posedge i_clk);
      i_a_load_wr <= 1'h1;
      i_a_load_data <= 32'h0003_0040;
      i_a_enable_set <= 1'h1;
      @(posedge i_clk);
      i_a_load_wr <= 1'h0;
      i_a_enable_set <= 1'h0;
      #1 chk(o_counter_b_value, 16'h0003);
      chk(o_counter_a_value, 32'h0003_0040);
      @(posedge i_clk);
      i_counter_a_freeze_bit <= 1'h1;
      repeat (5) @(posedge i_clk);
      #1 chk(o_counter_a_value, 32'h0003_003F);
      @(posedge i_clk);
      i_counter_a_freeze_bit <= 1'h0;
      i_a_load_wr <= 1'h1;
      i_a_load_data <= 32'h0000_0100;
      @(posedge i_clk);
      i_a_load_wr <= 1'h0;
      @(posedge i_clk);
      #1 chk(o_counter_a_value, 32'h0000_00FF);
      // ========================================
      // 16-bit counter B with prescale
      @(posedge i_clk);
      i_a_enable_clear <= 1'h1;
      @(posedge i_clk);
      i_a_enable_clear <= 1'h0;
      i_timer_config <= 3'h4;
      i_counter_b_mode_field <= 2'h1;
      i_b_load_wr <= 1'h1;
      i_b_load_data <= 16'h0003;
      i_b_prescale_wr <= 1'h1;
      i_b_prescale_data <= 8'h02;
      i_counter_b_trigger_out_enable <= 1'h1;
      i_irq_mask <= 3'h2;
      @(posedge i_clk);
      i_b_load_wr <= 1'h0;
      i_b_prescale_wr <= 1'h0;
      i_b_enable_set <= 1'h1;
      @(posedge i_clk);
      i_b_enable_set <= 1'h0;
      wait_raw(1);
      chk(n, 32'h0000_000C);
      chk(o_counter_b_value, 16'h0003);
      chk({o_b_enable, o_b_trigger, o_irq}, 3'h3);
      chk(o_masked_status, 3'h2);
      // Counter A in split mode, prescale left at reset
      @(posedge i_clk);
      i_a_load_wr <= 1'h1;
      i_a_load_data <= 32'h0000_0010;
      i_a_enable_set <= 1'h1;
      @(posedge i_clk);
      i_a_load_wr <= 1'h0;
      i_a_enable_set <= 1'h0;
      repeat (2) @(posedge i_clk);
      #1 chk(o_counter_a_value, 32'h0000_000E);
      // ========================================
      // Clock mode first load under freeze override
      @(posedge i_clk);
      i_a_enable_clear <= 1'h1;
      @(posedge i_clk);
      i_a_enable_clear <= 1'h0;
      i_timer_config <= 3'h1;
      i_a_enable_set <= 1'h1;
      i_counter_a_freeze_bit <= 1'h1;
      i_clock_freeze_override_bit <= 1'h1;
      @(posedge i_clk);
      i_a_enable_set <= 1'h0;
      #1 chk(o_counter_a_value, 32'h0000_0001);
      repeat (8) begin
         repeat (3) @(posedge i_clk);
         i_capture_compare_pin_0 <= ~i_capture_compare_pin_0;
      end
      #1 chk(o_counter_a_value, 32'h0000_0001);
      // ========================================
      // Reset in mid-run re-arms the first clock-mode load
      @(posedge i_clk);
      i_rst_n <= 1'h0;
      @(posedge i_clk);
      #1 chk(o_counter_a_value, 32'hFFFF_FFFF);
      chk(o_counter_b_value, 16'hFFFF);
      chk({o_a_enable, o_b_enable, o_raw_status, o_irq}, '0);
      @(posedge i_clk);
      i_rst_n <= 1'h1;
      @(posedge i_clk);
      #1 chk(o_counter_a_value, 32'h0000_0001);
      chk(o_masked_status, 3'h0);
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire
